// >>> logic/lvdsd_pkg.sv
// Package for the LVDS/CMOS channel divider block: register map, field layout, reset values
// and the structs that carry the register bus and the per-stage settings.
// Assumes a 9-bit byte address space on a plain strobe bus with 8-bit data.
package lvdsd_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;
    localparam int SYNC_FFS = 3;

    // Register offsets.
    localparam logic [8:0] OFF_A_S1_COUNTS = 9'h199;
    localparam logic [8:0] OFF_A_PHASES = 9'h19A;
    localparam logic [8:0] OFF_A_S2_COUNTS = 9'h19B;
    localparam logic [8:0] OFF_A_CONTROL = 9'h19C;
    localparam logic [8:0] OFF_A_DUTY_CORR = 9'h19D;
    localparam logic [8:0] OFF_B_S1_COUNTS = 9'h19E;
    localparam logic [8:0] OFF_STATUS = 9'h1A8;

    // Field positions.
    localparam int POS_LOW_LSB = 4;
    localparam int POS_HIGH_LSB = 0;
    localparam int POS_PHASE_S2_LSB = 4;
    localparam int POS_PHASE_S1_LSB = 0;
    localparam int POS_BYPASS_S2 = 5;
    localparam int POS_BYPASS_S1 = 4;
    localparam int POS_ALIGN_IGNORE = 3;
    localparam int POS_FORCE_LEVEL = 2;
    localparam int POS_START_S2 = 1;
    localparam int POS_START_S1 = 0;
    localparam int POS_DUTY_CORR_DIS = 0;
    localparam logic [7:0] CONTROL_MASK = 8'h3F;
    localparam logic [7:0] DUTY_CORR_MASK = 8'h01;

    // Reset values.
    localparam logic [7:0] RST_COUNTS = 8'h00;
    localparam logic [7:0] RST_PHASES = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_DUTY_CORR = 8'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } lvdsd_bus_req_t;

    typedef struct packed {
        logic [CNT_W-1:0] high;
        logic [CNT_W-1:0] low;
        logic [CNT_W-1:0] phase;
        logic start;
        logic bypass;
        logic hold;
    } lvdsd_stage_cfg_t;
endpackage

// >>> logic/lvdsd_top.sv
// Channel divider block: two cascaded stages for channel A, first stage of channel B,
// alignment input, force level, duty-cycle correction and the register file.
// Assumes a single clock whose enabled cycles drive the reference input clock, and an
// asynchronous active-low alignment pin from outside.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns

module lvdsd_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire lvdsd_pkg::lvdsd_bus_req_t bus_req,
    output logic [lvdsd_pkg::DATA_W-1:0] rdata,
    input wire logic align_n,
    output logic a_stage1_out,
    output logic a_stage2_out,
    output logic chan_a_out,
    output logic chan_b_out
);
    localparam int NST = 3;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [7:0] a_s1_counts_r;
    logic [7:0] a_phases_r;
    logic [7:0] a_s2_counts_r;
    logic [7:0] a_control_r;
    logic [7:0] a_duty_corr_r;
    logic [7:0] b_s1_counts_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] status;

    wire wr_go = ce & bus_req.wr;
    wire sel_a_s1 = bus_req.addr == lvdsd_pkg::OFF_A_S1_COUNTS;
    wire sel_a_ph = bus_req.addr == lvdsd_pkg::OFF_A_PHASES;
    wire sel_a_s2 = bus_req.addr == lvdsd_pkg::OFF_A_S2_COUNTS;
    wire sel_a_ctl = bus_req.addr == lvdsd_pkg::OFF_A_CONTROL;
    wire sel_a_dcc = bus_req.addr == lvdsd_pkg::OFF_A_DUTY_CORR;
    wire sel_b_s1 = bus_req.addr == lvdsd_pkg::OFF_B_S1_COUNTS;
    wire sel_stat = bus_req.addr == lvdsd_pkg::OFF_STATUS;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            a_s1_counts_r <= lvdsd_pkg::RST_COUNTS;
            a_phases_r <= lvdsd_pkg::RST_PHASES;
            a_s2_counts_r <= lvdsd_pkg::RST_COUNTS;
            a_control_r <= lvdsd_pkg::RST_CONTROL;
            a_duty_corr_r <= lvdsd_pkg::RST_DUTY_CORR;
            b_s1_counts_r <= lvdsd_pkg::RST_COUNTS;
        end else if (wr_go) begin
            if (sel_a_s1) a_s1_counts_r <= bus_req.wdata;
            if (sel_a_ph) a_phases_r <= bus_req.wdata;
            if (sel_a_s2) a_s2_counts_r <= bus_req.wdata;
            if (sel_a_ctl) a_control_r <= bus_req.wdata & lvdsd_pkg::CONTROL_MASK;
            if (sel_a_dcc) a_duty_corr_r <= bus_req.wdata & lvdsd_pkg::DUTY_CORR_MASK;
            if (sel_b_s1) b_s1_counts_r <= bus_req.wdata;
        end
    end

    assign rdata_nxt = sel_a_s1 ? a_s1_counts_r :
                       sel_a_ph ? a_phases_r :
                       sel_a_s2 ? a_s2_counts_r :
                       sel_a_ctl ? a_control_r :
                       sel_a_dcc ? a_duty_corr_r :
                       sel_b_s1 ? b_s1_counts_r :
                       sel_stat ? status : 8'h00;

    // Read data stands from the enabled edge after the strobe to the next enabled edge; it is zero otherwise.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (ce) begin
            rdata_r <= bus_req.rd ? rdata_nxt : 8'h00;
        end
    end
    assign rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Alignment pin: three flops, a change counts once the last two agree.
    logic [lvdsd_pkg::SYNC_FFS-1:0] align_ff_r;
    logic align_act_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            align_ff_r <= '1;
            align_act_r <= 1'b0;
        end else if (ce) begin
            align_ff_r <= {align_ff_r[1:0], align_n};
            if (align_ff_r[1] == align_ff_r[2]) align_act_r <= ~align_ff_r[2];
        end
    end

    wire align_ignore = a_control_r[lvdsd_pkg::POS_ALIGN_IGNORE];
    wire hold_a = align_act_r & ~align_ignore;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Reference input clock: one input cycle is two enabled clock cycles, tick on its rise.
    logic ref_lvl_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_lvl_r <= 1'b0;
        end else if (ce) begin
            ref_lvl_r <= ~ref_lvl_r;
        end
    end
    wire ref_tick = ce & ~ref_lvl_r;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Stages: 0 is A1, 1 is A2, 2 is B1.
    lvdsd_pkg::lvdsd_stage_cfg_t cfg [NST];
    logic [NST-1:0] in_tick;
    logic [NST-1:0] in_lvl;
    logic [NST-1:0] out_tick;
    logic [NST-1:0] out_lvl;

    assign cfg[0] = '{high: a_s1_counts_r[3:0], low: a_s1_counts_r[7:4],
                      phase: a_phases_r[3:0],
                      start: a_control_r[lvdsd_pkg::POS_START_S1],
                      bypass: a_control_r[lvdsd_pkg::POS_BYPASS_S1], hold: hold_a};
    assign cfg[1] = '{high: a_s2_counts_r[3:0], low: a_s2_counts_r[7:4],
                      phase: a_phases_r[7:4],
                      start: a_control_r[lvdsd_pkg::POS_START_S2],
                      bypass: a_control_r[lvdsd_pkg::POS_BYPASS_S2], hold: hold_a};
    // Channel B's remaining controls live elsewhere; this stage obeys alignment, starts low.
    assign cfg[2] = '{high: b_s1_counts_r[3:0], low: b_s1_counts_r[7:4],
                      phase: 4'h0, start: 1'b0, bypass: 1'b0, hold: align_act_r};

    assign in_tick[0] = ref_tick;
    assign in_lvl[0] = ref_lvl_r;
    assign in_tick[1] = out_tick[0];
    assign in_lvl[1] = out_lvl[0];
    assign in_tick[2] = ref_tick;
    assign in_lvl[2] = ref_lvl_r;

    genvar g;
    generate
        for (g = 0; g < NST; g++) begin : g_stage
            logic [4:0] cnt_r;
            logic [4:0] cnt_nxt;
            logic lvl_r;
            logic lvl_nxt;
            wire [4:0] seg_load = {1'b0, lvl_r ? cfg[g].low : cfg[g].high};
            wire [4:0] first_load = {1'b0, cfg[g].phase} +
                                    {1'b0, cfg[g].start ? cfg[g].high : cfg[g].low};
            wire run = ~cfg[g].hold & ~cfg[g].bypass;
            wire edge_now = run & in_tick[g] & (cnt_r == 5'h00);

            // A held or bypassed stage is parked at its start level with its first
            // segment preloaded, so the release lands phase input cycles late.
            assign lvl_nxt = !run ? cfg[g].start : (edge_now ? ~lvl_r : lvl_r);
            assign cnt_nxt = !run ? first_load :
                             !in_tick[g] ? cnt_r :
                             edge_now ? seg_load : 5'(cnt_r - 5'h01);

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    cnt_r <= 5'h00;
                    lvl_r <= 1'b0;
                end else if (ce) begin
                    cnt_r <= cnt_nxt;
                    lvl_r <= lvl_nxt;
                end
            end

            assign out_lvl[g] = cfg[g].bypass ? in_lvl[g] : lvl_r;
            assign out_tick[g] = cfg[g].bypass ? in_tick[g] : (edge_now & ~lvl_r);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////
    // Duty-cycle correction: measure the A2 period in reference cycles and regenerate a
    // half-period high pulse. It trails the raw output by one period after any change.
    logic [8:0] per_cnt_r;
    logic [8:0] half_r;
    logic [8:0] hi_cnt_r;
    logic dcc_lvl_r;
    wire dcc_on = ~a_duty_corr_r[lvdsd_pkg::POS_DUTY_CORR_DIS];
    wire a2_rise = out_tick[1];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            per_cnt_r <= 9'h000;
            half_r <= 9'h000;
            hi_cnt_r <= 9'h000;
            dcc_lvl_r <= 1'b0;
        end else if (ce && ref_tick) begin
            if (a2_rise) begin
                per_cnt_r <= 9'h001;
                half_r <= {1'b0, per_cnt_r[8:1]};
                hi_cnt_r <= 9'h001;
                dcc_lvl_r <= 1'b1;
            end else begin
                per_cnt_r <= (per_cnt_r == 9'h1FF) ? per_cnt_r : 9'(per_cnt_r + 9'h001);
                hi_cnt_r <= 9'(hi_cnt_r + 9'h001);
                if (hi_cnt_r >= half_r) dcc_lvl_r <= 1'b0;
            end
        end
    end

    wire a_level = (dcc_on && half_r != 9'h000) ? dcc_lvl_r : out_lvl[1];
    // Forcing only bites once alignment is ignored, so a forced output cannot be re-aligned.
    assign chan_a_out = align_ignore ? a_control_r[lvdsd_pkg::POS_FORCE_LEVEL] : a_level;
    assign a_stage1_out = out_lvl[0];
    assign a_stage2_out = out_lvl[1];
    assign chan_b_out = out_lvl[2];
    assign status = {4'h0, align_act_r, chan_b_out, a_stage2_out, a_stage1_out};

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // A run is only judged when it was loaded after the last write and outside a park,
    // since a segment loaded from older counts may legally run to its old length.
    logic [4:0] a1_run_len_r;
    logic a1_clean_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            a1_run_len_r <= 5'h00;
            a1_clean_r <= 1'b0;
        end else if (wr_go || !g_stage[0].run) begin
            a1_run_len_r <= 5'h00;
            a1_clean_r <= 1'b0;
        end else if (ref_tick) begin
            a1_run_len_r <= g_stage[0].edge_now ? 5'h00 : 5'(a1_run_len_r + 5'h01);
            if (g_stage[0].edge_now) a1_clean_r <= 1'b1;
        end
    end

    a1_low_len_a: assert property (ref_tick && g_stage[0].edge_now && !g_stage[0].lvl_r
        && a1_clean_r |-> a1_run_len_r == {1'b0, cfg[0].low})
        else $error("stage A1 low run wrong length");
    a1_high_len_a: assert property (ref_tick && g_stage[0].edge_now && g_stage[0].lvl_r
        && a1_clean_r |-> a1_run_len_r == {1'b0, cfg[0].high})
        else $error("stage A1 high run wrong length");
    a2_from_a1_a: assert property (g_stage[1].edge_now |=> $rose(a_stage1_out))
        else $error("stage A2 moved without A1 rise");
    a1_bypass_a: assert property (cfg[0].bypass |-> a_stage1_out == ref_lvl_r)
        else $error("stage A1 bypass not passing input");
    a2_bypass_a: assert property (cfg[1].bypass |-> a_stage2_out == a_stage1_out)
        else $error("stage A2 bypass not passing input");
    a_hold_a: assert property (ce && hold_a && !cfg[0].bypass |=> a_stage1_out
        == $past(cfg[0].start))
        else $error("stage A1 not parked at start level");
    a2_start_a: assert property (ce && hold_a && !cfg[1].bypass |=> a_stage2_out
        == $past(cfg[1].start))
        else $error("stage A2 not parked at start level");
    force_lvl_a: assert property (align_ignore |-> chan_a_out
        == a_control_r[lvdsd_pkg::POS_FORCE_LEVEL])
        else $error("forced level not on channel output");
    ignore_a: assert property (align_ignore |-> !hold_a)
        else $error("alignment not ignored");
    release_a: assert property (ce && $fell(hold_a) && !cfg[0].bypass
        |-> g_stage[0].cnt_r == 5'(cfg[0].phase + (cfg[0].start ? cfg[0].high : cfg[0].low)))
        else $error("phase offset not loaded on release");
    raw_dcc_a: assert property (!dcc_on |-> align_ignore || chan_a_out == a_stage2_out)
        else $error("correction active while disabled");
    b_park_a: assert property (ce && align_act_r |=> !chan_b_out)
        else $error("stage B1 not parked low");

    rise_c: cover property (out_tick[1]);
    release_c: cover property ($fell(hold_a));
    force_c: cover property (align_ignore && chan_a_out);
    bypass_c: cover property (cfg[0].bypass && cfg[1].bypass);
endmodule

// >>> verif/lvdsd_rx_model.sv
// Receiver model for one divided clock output: keeps the length of the last finished
// high run and low run, counted in system clock cycles.
// Assumes the output is sampled on the system clock and ce stays high while measuring.
`timescale 1ns/1ns
module lvdsd_rx_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_in,
    output int high_len,
    output int low_len
);
    logic last_r;
    int run_r;

    // A run is stored only when it ends, so a parked output keeps the older figures.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            last_r <= 1'b0;
            run_r <= 1;
            high_len <= 0;
            low_len <= 0;
        end else if (clk_in !== last_r) begin
            if (last_r) begin
                high_len <= run_r;
            end else begin
                low_len <= run_r;
            end
            last_r <= clk_in;
            run_r <= 1;
        end else begin
            run_r <= run_r + 1;
        end
    end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the channel divider: register map, run lengths, park and force.
// Assumes one 100 MHz clock; read data are checked one cycle after each read strobe.
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic align_n = 1'b1;
    lvdsd_pkg::lvdsd_bus_req_t bus_req = '0;
    logic [7:0] rdata;
    logic a1, a2, ca, cb;
    logic v;
    int h1, l1, h2, l2, hca, lca, hcb, lcb, d0, d1;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic rd_d = 1'b0;
    logic [7:0] exp_q[$];
    logic [8:0] offs[6] = '{9'h199, 9'h19A, 9'h19B, 9'h19C, 9'h19D, 9'h19E};
    logic [7:0] masks[6] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h01, 8'hFF};

    always #5 clk = ~clk;

    lvdsd_top u_lvdsd_top (.clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req), .rdata(rdata),
        .align_n(align_n), .a_stage1_out(a1), .a_stage2_out(a2), .chan_a_out(ca),
        .chan_b_out(cb));
    lvdsd_rx_model u_lvdsd_rx_model_a1 (.clk(clk), .rst_n(rst_n), .clk_in(a1),
        .high_len(h1), .low_len(l1));
    lvdsd_rx_model u_lvdsd_rx_model_a2 (.clk(clk), .rst_n(rst_n), .clk_in(a2),
        .high_len(h2), .low_len(l2));
    lvdsd_rx_model u_lvdsd_rx_model_ca (.clk(clk), .rst_n(rst_n), .clk_in(ca),
        .high_len(hca), .low_len(lca));
    lvdsd_rx_model u_lvdsd_rx_model_cb (.clk(clk), .rst_n(rst_n), .clk_in(cb),
        .high_len(hcb), .low_len(lcb));

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk);
        bus_req.rd <= 1'b0;
    endtask

    // The settle time covers the old segment, one measured period and two full periods
    // of the slowest channel A output, so corrected runs are stored from the new setting.
    task automatic div_case(input logic [7:0] ctrl, input logic dis);
        logic [3:0] f[6];
        int t1l, t1h, t2l, t2h, hi;
        for (int i = 0; i < 6; i++) begin
            f[i] = 4'($urandom_range(15));
        end
        f[2] = f[2] & 4'h3;
        f[3] = f[3] & 4'h3;
        wr(lvdsd_pkg::OFF_A_S1_COUNTS, {f[1], f[0]});
        wr(lvdsd_pkg::OFF_A_S2_COUNTS, {f[3], f[2]});
        wr(lvdsd_pkg::OFF_B_S1_COUNTS, {f[5], f[4]});
        wr(lvdsd_pkg::OFF_A_CONTROL, ctrl);
        wr(lvdsd_pkg::OFF_A_DUTY_CORR, {7'h00, dis});
        repeat (2200) @(posedge clk);
        t1l = ctrl[4] ? 1 : 2 * (f[1] + 1);
        t1h = ctrl[4] ? 1 : 2 * (f[0] + 1);
        t2l = ctrl[5] ? t1l : (f[3] + 1) * (t1l + t1h);
        t2h = ctrl[5] ? t1h : (f[2] + 1) * (t1l + t1h);
        hi = dis ? t2h : 2 * ((t2l + t2h) / 4);
        check(16'(l1), 16'(t1l), "a1 low");
        check(16'(h1), 16'(t1h), "a1 high");
        check(16'(l2), 16'(t2l), "a2 low");
        check(16'(h2), 16'(t2h), "a2 high");
        check(16'(lcb), 16'(2 * (f[5] + 1)), "b1 low");
        check(16'(hcb), 16'(2 * (f[4] + 1)), "b1 high");
        check(16'(hca), 16'(hi), "chan a high");
        check(16'(lca), 16'(t2l + t2h - hi), "chan a low");
    endtask

    task automatic align_delay(input logic [7:0] ph, output int d);
        wr(lvdsd_pkg::OFF_A_PHASES, ph);
        @(posedge clk);
        align_n <= 1'b0;
        repeat (10) @(posedge clk);
        align_n <= 1'b1;
        d = 0;
        while (a1 !== 1'b1 && d < 200) begin
            @(posedge clk);
            d++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        rd_d <= bus_req.rd & ce;
        cycles++;
        if (rd_d) begin
            check({8'h00, rdata}, {8'h00, exp_q.pop_front()}, "read");
        end
        if (cycles == 30000) begin
            failures++;
            final_report();
        end
    end

    initial begin
        void'($urandom(48218));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(offs[i], 8'h00);
        end
        for (int i = 0; i < 6; i++) begin
            d0 = $urandom_range(255);
            wr(offs[i], 8'(d0));
            rd(offs[i], 8'(d0) & masks[i]);
        end
        wr(9'h1FF, 8'hA5);
        rd(9'h1FF, 8'h00);
        wr(lvdsd_pkg::OFF_A_PHASES, 8'h00);
        @(posedge clk);
        ce <= 1'b0;
        wr(lvdsd_pkg::OFF_A_PHASES, 8'h5A);
        ce <= 1'b1;
        rd(lvdsd_pkg::OFF_A_PHASES, 8'h00);
        div_case(8'h00, 1'b1);
        div_case(8'h00, 1'b0);
        div_case(8'h10, 1'b1);
        div_case(8'h20, 1'b1);
        div_case(8'h30, 1'b1);
        wr(lvdsd_pkg::OFF_A_S1_COUNTS, 8'h00);
        wr(lvdsd_pkg::OFF_A_CONTROL, 8'h03);
        align_n <= 1'b0;
        repeat (12) @(posedge clk);
        check({15'h0, a1}, 16'h1, "a1 park");
        check({15'h0, a2}, 16'h1, "a2 park");
        check({15'h0, cb}, 16'h0, "b1 park");
        wr(lvdsd_pkg::OFF_A_CONTROL, 8'h08);
        repeat (4) @(posedge clk);
        v = a1;
        repeat (2) @(posedge clk);
        check({15'h0, a1}, {15'h0, ~v}, "a1 ignores");
        wr(lvdsd_pkg::OFF_A_CONTROL, 8'h0C);
        repeat (2) @(posedge clk);
        check({15'h0, ca}, 16'h1, "force high");
        wr(lvdsd_pkg::OFF_A_CONTROL, 8'h08);
        repeat (2) @(posedge clk);
        check({15'h0, ca}, 16'h0, "force low");
        align_n <= 1'b1;
        wr(lvdsd_pkg::OFF_A_CONTROL, 8'h00);
        align_delay(8'h00, d0);
        align_delay(8'h07, d1);
        check({15'h0, (d1 - d0 >= 13 && d1 - d0 <= 15)}, 16'h1, "phase delay");
        repeat (20) @(posedge clk);
        final_report();
    end
endmodule
